// ==== inc/dcr_pkg.sv ====
// Purpose: constants and carrier types of the decoder configuration bank
// Assumes: 4-bit register addresses and 4-bit data words
// Notes:   reset values are the power-on states of each register
package dcr_pkg;

    // register addresses
    localparam logic [3:0] ADDR_PLL_BW    = 4'h8;
    localparam logic [3:0] ADDR_AUDIO_OUT = 4'hA;
    localparam logic [3:0] ADDR_SPEED     = 4'hB;
    localparam logic [3:0] ADDR_VPIN_LO   = 4'hC;
    localparam logic [3:0] ADDR_VPIN_HI   = 4'hD;
    localparam logic [3:0] ADDR_AUD_MOTOR = 4'hE;
    localparam logic [3:0] ADDR_SUBCODE   = 4'hF;

    // power-on values
    localparam logic [3:0] RST_PLL_BW     = 4'h9;
    localparam logic [3:0] RST_AUDIO_OUT  = 4'h2;
    localparam logic [3:0] RST_SPEED      = 4'h0;
    localparam logic [3:0] RST_VPIN_LO    = 4'h2;
    localparam logic [3:0] RST_VPIN_HI    = 4'hF;
    localparam logic [3:0] RST_AUD_MOTOR  = 4'h4;
    localparam logic [3:0] RST_SUBCODE    = 4'h0;

    localparam int NUM_REGS = 7;
    localparam int IDX_PLL_BW    = 0;
    localparam int IDX_AUDIO_OUT = 1;
    localparam int IDX_SPEED     = 2;
    localparam int IDX_VPIN_LO   = 3;
    localparam int IDX_VPIN_HI   = 4;
    localparam int IDX_AUD_MOTOR = 5;
    localparam int IDX_SUBCODE   = 6;

    // field positions
    localparam int PLL_LOOP_LSB  = 0;
    localparam int PLL_INT_LSB   = 2;
    localparam int AO_ACC_LO     = 0;
    localparam int AO_POST       = 1;
    localparam int AO_ACC_HI     = 2;
    localparam int AO_FLAGS      = 3;
    localparam int SP_STBY_LSB   = 0;
    localparam int SP_XTAL       = 2;
    localparam int SP_DOUBLE     = 3;
    localparam int VL_OT_EXT     = 0;
    localparam int VL_SINGLE     = 1;
    localparam int VL_V3_LEVEL   = 2;
    localparam int VH_V4_LSB     = 0;
    localparam int VH_V5_LSB     = 2;
    localparam int AM_BRAKE      = 0;
    localparam int AM_LTD        = 1;
    localparam int AM_AF_LSB     = 2;
    localparam int SC_ON_LSB     = 0;
    localparam int SC_3WIRE      = 3;

    // field codes
    localparam logic [1:0] STBY_STOP  = 2'h0;
    localparam logic [1:0] STBY_PAUSE = 2'h2;
    localparam logic [1:0] STBY_RUN   = 2'h3;
    localparam logic [1:0] PIN_FUNC   = 2'h1;
    localparam logic [1:0] PIN_LOW    = 2'h2;
    localparam logic [1:0] PIN_HIGH   = 2'h3;
    localparam logic [1:0] AF_ON      = 2'h1;
    localparam logic [2:0] SUB_ON     = 3'h4;
    localparam logic [3:0] VH_MOTOR4  = 4'h0;

    typedef enum logic [2:0] {
        RM_STOP  = 3'h1,
        RM_PAUSE = 3'h2,
        RM_RUN   = 3'h4
    } dcr_run_mode_t;

    // code is {bit 2, bit 0} of the audio output register
    typedef enum logic [1:0] {
        ACC_LEVEL2 = 2'h0,
        ACC_LEVEL1 = 2'h1,
        ACC_LEVEL3 = 2'h2,
        ACC_OFF    = 2'h3
    } dcr_clk_acc_t;

    typedef enum logic [1:0] {
        XTAL_33M8 = 2'h0,
        XTAL_8M46 = 2'h1,
        XTAL_16M9 = 2'h2
    } dcr_xtal_t;

    typedef struct packed {
        logic         post_conceal;
        logic         flags_on;
        logic         output_off;
        dcr_clk_acc_t accuracy;
    } dcr_audio_cfg_t;

    typedef struct packed {
        logic          double_speed;
        dcr_xtal_t     xtal;
        dcr_run_mode_t mode;
        logic          audio_feat_on;
        logic          lock_to_disc;
        logic          brake_6pct;
        logic          motor_4line;
        logic          deemph_bypass;
    } dcr_drive_cfg_t;

    typedef struct packed {
        logic [1:0] loop_bw;
        logic [1:0] int_bw;
    } dcr_pll_cfg_t;

    typedef struct packed {
        logic enable;
        logic three_wire;
    } dcr_subcode_cfg_t;

endpackage

// ==== hdl/dcr_reg4.sv ====
// Purpose: one write-only 4-bit configuration register
// Assumes: write strobe and data come from the same clock domain
// Notes:   power-on value given per instance
`timescale 1ns/100ps
module dcr_reg4
#(
    parameter logic [3:0] ADDR  = 4'h0,
    parameter logic [3:0] RESET = 4'h0
)
(
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       wr_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [3:0] data_in,
    output logic      [3:0] value_out
);
    logic [3:0] value_ff;
    logic [3:0] nxt_value;

    always_comb
    begin
        nxt_value = value_ff;
        if (wr_in && (addr_in == ADDR))
        begin
            nxt_value = data_in;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            value_ff <= RESET;
        end
        else
        begin
            value_ff <= nxt_value;
        end
    end

    assign value_out = value_ff;
endmodule // dcr_reg4

// ==== hdl/dcr_pin_sync.sv ====
// Purpose: bring an asynchronous pin into the core clock domain
// Assumes: pin level changes slowly against the core clock
// Notes:   a change counts only once stages two and three agree
`timescale 1ns/100ps
module dcr_pin_sync
(
    input  wire logic core_clk_in,
    input  wire logic rstn_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic [2:0] stage_ff;
    logic [2:0] nxt_stage;
    logic       level_ff;
    logic       nxt_level;

    always_comb
    begin
        nxt_stage = {stage_ff[1:0], pin_in};
        nxt_level = level_ff;
        // stage 0 is metastable; only stages 1 and 2 are compared
        if (stage_ff[1] == stage_ff[2])
        begin
            nxt_level = stage_ff[2];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            stage_ff <= 3'h0;
            level_ff <= 1'b0;
        end
        else
        begin
            stage_ff <= nxt_stage;
            level_ff <= nxt_level;
        end
    end

    assign level_out = level_ff;
endmodule // dcr_pin_sync

// ==== hdl/dcr_top.sv ====
// Purpose: configuration register bank of the disc decoder and servo core
// Assumes: the serial controller port delivers decoded address/data writes
// Notes:   write-only bank; unlisted addresses belong to other blocks
//
// What this block does
// RULE1: audio bit 1 picks pre or post concealment data; bit 3 adds flags.
// RULE2: bits 2,0 set clock accuracy level; 11 turns output off, held low.
// RULE3: speed bit 2 declares crystal; select pin picks the low crystal.
// RULE4: speed bit 3 double speed; bits 1:0 stop, pause or run.
// RULE5: pin one feeds external off-track when set, else readable on status.
// RULE6: pins-low register bits 2:1 set single or split mute outputs.
// RULE7: pins-high value 0000 makes pins four and five motor outputs.
// RULE8: pins-high bits 1:0 make pin four subcode, low or high.
// RULE9: pins-high bits 3:2 make pin five de-emphasis flag, low or high.
// RULE10: pll register sets loop and internal bandwidth; reset value 1001.
// RULE11: after reset every register holds its power-on value.
// RULE12: audio/motor and subcode register fields drive their options.
`timescale 1ns/100ps
module dcr_top
(
    input  wire logic                 core_clk_in,
    input  wire logic                 rstn_in,
    // register write port
    input  wire logic                 reg_wr_in,
    input  wire logic [3:0]           reg_addr_in,
    input  wire logic [3:0]           reg_data_in,
    // asynchronous pins
    input  wire logic                 pll_clock_select_pin_in,
    input  wire logic                 versatile_pin_one_in,
    // same-clock sources
    input  wire logic                 audio_pre_conceal_in,
    input  wire logic                 audio_post_conceal_in,
    input  wire logic                 mute_left_in,
    input  wire logic                 mute_right_in,
    input  wire logic                 internal_off_track_in,
    input  wire logic                 qw_subcode_in,
    input  wire logic                 deemph_flag_in,
    input  wire logic                 motor_a_in,
    input  wire logic                 motor_b_in,
    // pins and settings
    output logic                      audio_serial_out,
    output logic                      mute_out,
    output logic                      versatile_pin_three_out,
    output logic                      versatile_pin_four_out,
    output logic                      versatile_pin_five_out,
    output logic                      off_track_out,
    output logic                      status_pin_one_out,
    output dcr_pkg::dcr_audio_cfg_t   audio_cfg_out,
    output dcr_pkg::dcr_drive_cfg_t   drive_cfg_out,
    output dcr_pkg::dcr_pll_cfg_t     pll_cfg_out,
    output dcr_pkg::dcr_subcode_cfg_t subcode_cfg_out
);

    localparam logic [3:0] ADDRS [dcr_pkg::NUM_REGS] = '{
        dcr_pkg::ADDR_PLL_BW,  dcr_pkg::ADDR_AUDIO_OUT, dcr_pkg::ADDR_SPEED,
        dcr_pkg::ADDR_VPIN_LO, dcr_pkg::ADDR_VPIN_HI,
        dcr_pkg::ADDR_AUD_MOTOR, dcr_pkg::ADDR_SUBCODE};
    localparam logic [3:0] RSTS [dcr_pkg::NUM_REGS] = '{
        dcr_pkg::RST_PLL_BW,  dcr_pkg::RST_AUDIO_OUT, dcr_pkg::RST_SPEED,
        dcr_pkg::RST_VPIN_LO, dcr_pkg::RST_VPIN_HI,
        dcr_pkg::RST_AUD_MOTOR, dcr_pkg::RST_SUBCODE};

    logic [3:0] regs [dcr_pkg::NUM_REGS];

    // addresses outside this bank simply match no instance
    genvar g;
    generate
        for (g = 0; g < dcr_pkg::NUM_REGS; g++)
        begin : g_reg
            dcr_reg4
            #(
                .ADDR  (ADDRS[g]),
                .RESET (RSTS[g])   // [RULE11] [RULE10]
            )
            u_reg
            (
                .core_clk_in (core_clk_in),
                .rstn_in     (rstn_in),
                .wr_in       (reg_wr_in),
                .addr_in     (reg_addr_in),
                .data_in     (reg_data_in),
                .value_out   (regs[g])
            );
        end
    endgenerate

    logic pll_clock_select_pin_lvl;
    logic pin_one_lvl;

    dcr_pin_sync u_sync_pll_clock_select_pin
    (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .pin_in      (pll_clock_select_pin_in),
        .level_out   (pll_clock_select_pin_lvl)
    );

    dcr_pin_sync u_sync_pin_one
    (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .pin_in      (versatile_pin_one_in),
        .level_out   (pin_one_lvl)
    );

    logic [3:0] r_pll;
    logic [3:0] r_ao;
    logic [3:0] r_sp;
    logic [3:0] r_vl;
    logic [3:0] r_vh;
    logic [3:0] r_am;
    logic [3:0] r_sc;

    assign r_pll = regs[dcr_pkg::IDX_PLL_BW];
    assign r_ao  = regs[dcr_pkg::IDX_AUDIO_OUT];
    assign r_sp  = regs[dcr_pkg::IDX_SPEED];
    assign r_vl  = regs[dcr_pkg::IDX_VPIN_LO];
    assign r_vh  = regs[dcr_pkg::IDX_VPIN_HI];
    assign r_am  = regs[dcr_pkg::IDX_AUD_MOTOR];
    assign r_sc  = regs[dcr_pkg::IDX_SUBCODE];

    // decoded settings
    dcr_pkg::dcr_audio_cfg_t   audio_cfg_ff;
    dcr_pkg::dcr_audio_cfg_t   nxt_audio_cfg;
    dcr_pkg::dcr_drive_cfg_t   drive_cfg_ff;
    dcr_pkg::dcr_drive_cfg_t   nxt_drive_cfg;
    dcr_pkg::dcr_pll_cfg_t     pll_cfg_ff;
    dcr_pkg::dcr_pll_cfg_t     nxt_pll_cfg;
    dcr_pkg::dcr_subcode_cfg_t subcode_cfg_ff;
    dcr_pkg::dcr_subcode_cfg_t nxt_subcode_cfg;

    always_comb
    begin
        nxt_audio_cfg.post_conceal = r_ao[dcr_pkg::AO_POST]; // [RULE1]
        nxt_audio_cfg.flags_on     = r_ao[dcr_pkg::AO_FLAGS]; // [RULE1]
        nxt_audio_cfg.accuracy     = dcr_pkg::dcr_clk_acc_t'(
            {r_ao[dcr_pkg::AO_ACC_HI], r_ao[dcr_pkg::AO_ACC_LO]}); // [RULE2]
        nxt_audio_cfg.output_off   =
            (nxt_audio_cfg.accuracy == dcr_pkg::ACC_OFF); // [RULE2]

        nxt_drive_cfg.double_speed = r_sp[dcr_pkg::SP_DOUBLE]; // [RULE4]
        if (r_sp[dcr_pkg::SP_XTAL])
        begin
            nxt_drive_cfg.xtal = dcr_pkg::XTAL_16M9; // [RULE3]
        end
        else if (pll_clock_select_pin_lvl)
        begin
            nxt_drive_cfg.xtal = dcr_pkg::XTAL_8M46; // [RULE3]
        end
        else
        begin
            nxt_drive_cfg.xtal = dcr_pkg::XTAL_33M8; // [RULE3]
        end
        // undefined code 01 falls back to the safest state, stop
        case (r_sp[dcr_pkg::SP_STBY_LSB +: 2])
            dcr_pkg::STBY_RUN:   nxt_drive_cfg.mode = dcr_pkg::RM_RUN;
            dcr_pkg::STBY_PAUSE: nxt_drive_cfg.mode = dcr_pkg::RM_PAUSE;
            default:             nxt_drive_cfg.mode = dcr_pkg::RM_STOP;
        endcase // [RULE4]
        nxt_drive_cfg.audio_feat_on =
            (r_am[dcr_pkg::AM_AF_LSB +: 2] == dcr_pkg::AF_ON); // [RULE12]
        nxt_drive_cfg.lock_to_disc  = r_am[dcr_pkg::AM_LTD]; // [RULE12]
        nxt_drive_cfg.brake_6pct    = r_am[dcr_pkg::AM_BRAKE]; // [RULE12]
        nxt_drive_cfg.motor_4line   = (r_vh == dcr_pkg::VH_MOTOR4); // [RULE7]
        nxt_drive_cfg.deemph_bypass =
            (r_vh[dcr_pkg::VH_V5_LSB +: 2] == dcr_pkg::PIN_FUNC);  // [RULE9]

        nxt_pll_cfg.loop_bw = r_pll[dcr_pkg::PLL_LOOP_LSB +: 2];  // [RULE10]
        nxt_pll_cfg.int_bw  = r_pll[dcr_pkg::PLL_INT_LSB +: 2];   // [RULE10]

        nxt_subcode_cfg.enable =
            (r_sc[dcr_pkg::SC_ON_LSB +: 3] == dcr_pkg::SUB_ON); // [RULE12]
        nxt_subcode_cfg.three_wire = r_sc[dcr_pkg::SC_3WIRE]; // [RULE12]
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            audio_cfg_ff   <= '0;
            drive_cfg_ff   <= '0;
            pll_cfg_ff     <= '0;
            subcode_cfg_ff <= '0;
        end
        else
        begin
            audio_cfg_ff   <= nxt_audio_cfg;
            drive_cfg_ff   <= nxt_drive_cfg;
            pll_cfg_ff     <= nxt_pll_cfg;
            subcode_cfg_ff <= nxt_subcode_cfg;
        end
    end

    // pin drivers
    logic audio_ff;
    logic nxt_audio;
    logic mute_ff;
    logic nxt_mute;
    logic v3_ff;
    logic nxt_v3;
    logic v4_ff;
    logic nxt_v4;
    logic v5_ff;
    logic nxt_v5;
    logic ot_ff;
    logic nxt_ot;
    logic st1_ff;
    logic nxt_st1;

    function automatic logic pin_sel(input logic [1:0] code,
                                     input logic       func);
        case (code)
            dcr_pkg::PIN_FUNC: pin_sel = func;
            dcr_pkg::PIN_LOW:  pin_sel = 1'b0;
            default:           pin_sel = 1'b1;
        endcase
    endfunction

    always_comb
    begin
        // output off holds the line low regardless of the data choice
        if (nxt_audio_cfg.output_off)
        begin
            nxt_audio = 1'b0; // [RULE2]
        end
        else if (r_ao[dcr_pkg::AO_POST])
        begin
            nxt_audio = audio_post_conceal_in; // [RULE1]
        end
        else
        begin
            nxt_audio = audio_pre_conceal_in; // [RULE1]
        end

        if (r_vl[dcr_pkg::VL_SINGLE])
        begin
            nxt_mute = mute_left_in | mute_right_in; // [RULE6]
            nxt_v3   = r_vl[dcr_pkg::VL_V3_LEVEL]; // [RULE6]
        end
        else
        begin
            nxt_mute = mute_left_in; // [RULE6]
            nxt_v3   = mute_right_in; // [RULE6]
        end

        if (r_vl[dcr_pkg::VL_OT_EXT])
        begin
            nxt_ot  = pin_one_lvl; // [RULE5]
            nxt_st1 = 1'b0;
        end
        else
        begin
            nxt_ot  = internal_off_track_in; // [RULE5]
            nxt_st1 = pin_one_lvl; // [RULE5]
        end

        if (r_vh == dcr_pkg::VH_MOTOR4)
        begin
            nxt_v4 = motor_a_in; // [RULE7]
            nxt_v5 = motor_b_in; // [RULE7]
        end
        else
        begin
            nxt_v4 = pin_sel(r_vh[dcr_pkg::VH_V4_LSB +: 2],
                             qw_subcode_in); // [RULE8]
            nxt_v5 = pin_sel(r_vh[dcr_pkg::VH_V5_LSB +: 2],
                             deemph_flag_in); // [RULE9]
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            audio_ff <= 1'b0;
            mute_ff  <= 1'b0;
            v3_ff    <= 1'b0;
            v4_ff    <= 1'b1;
            v5_ff    <= 1'b1;
            ot_ff    <= 1'b0;
            st1_ff   <= 1'b0;
        end
        else
        begin
            audio_ff <= nxt_audio;
            mute_ff  <= nxt_mute;
            v3_ff    <= nxt_v3;
            v4_ff    <= nxt_v4;
            v5_ff    <= nxt_v5;
            ot_ff    <= nxt_ot;
            st1_ff   <= nxt_st1;
        end
    end

    assign audio_serial_out        = audio_ff;
    assign mute_out                = mute_ff;
    assign versatile_pin_three_out = v3_ff;
    assign versatile_pin_four_out  = v4_ff;
    assign versatile_pin_five_out  = v5_ff;
    assign off_track_out           = ot_ff;
    assign status_pin_one_out      = st1_ff;
    assign audio_cfg_out           = audio_cfg_ff;
    assign drive_cfg_out           = drive_cfg_ff;
    assign pll_cfg_out             = pll_cfg_ff;
    assign subcode_cfg_out         = subcode_cfg_ff;
endmodule // dcr_top

// ==== dv/dcr_host_model.sv ====
// Purpose: microcontroller side that loads configuration words
// Assumes: signals change 1 ns after an edge and hold to the next edge
// Notes:   no readback exists, so the model only writes
`timescale 1ns/100ps
module dcr_host_model
(
    input  wire logic       clk_in,
    output logic            wr_out,
    output logic [3:0]      addr_out,
    output logic [3:0]      data_out
);
    initial {wr_out, addr_out, data_out} = '0;
    // strobe stays up so calls in a row give back-to-back writes
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        wr_out = 1'b1;
        addr_out = a;
        data_out = d; // crystal fitted is declared in the speed word
        @(posedge clk_in);
        #1;
    endtask
    // released bus shows no stale word
    task automatic idle();
        wr_out = 1'b0;
        addr_out = ~addr_out;
        data_out = ~data_out;
    endtask
endmodule // dcr_host_model

// ==== dv/dcr_top_assertions.sv ====
// Purpose: write-to-output relations of the configuration bank
// Assumes: a write taken at one edge shows at the outputs two samples on
// Notes:   synchronised pin paths are left to the bench
`timescale 1ns/100ps
module dcr_top_assertions
(
    input wire logic                      core_clk_in,
    input wire logic                      rstn_in,
    input wire logic                      reg_wr_in,
    input wire logic [3:0]                reg_addr_in,
    input wire logic [3:0]                reg_data_in,
    input wire logic                      audio_pre_conceal_in,
    input wire logic                      audio_post_conceal_in,
    input wire logic                      mute_left_in,
    input wire logic                      mute_right_in,
    input wire logic                      internal_off_track_in,
    input wire logic                      qw_subcode_in,
    input wire logic                      audio_serial_out,
    input wire logic                      mute_out,
    input wire logic                      versatile_pin_three_out,
    input wire logic                      versatile_pin_four_out,
    input wire logic                      off_track_out,
    input wire logic                      status_pin_one_out,
    input wire dcr_pkg::dcr_audio_cfg_t   audio_cfg_out,
    input wire dcr_pkg::dcr_drive_cfg_t   drive_cfg_out,
    input wire dcr_pkg::dcr_pll_cfg_t     pll_cfg_out,
    input wire dcr_pkg::dcr_subcode_cfg_t subcode_cfg_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);
    function automatic logic [2:0] mode_of(input logic [1:0] c);
        return (c == 2'h3) ? 3'h4 : (c == 2'h2) ? 3'h2 : 3'h1;
    endfunction
    sequence s_wr(logic [3:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    property p_ao_fields;
        s_wr(dcr_pkg::ADDR_AUDIO_OUT) |-> ##2
            audio_cfg_out.post_conceal == $past(reg_data_in[1], 2) &&
            audio_cfg_out.flags_on == $past(reg_data_in[3], 2);
    endproperty
    a_ao_fields: assert property (p_ao_fields)
        else $error("audio source or flag select wrong");
    property p_ao_acc;
        s_wr(dcr_pkg::ADDR_AUDIO_OUT) |-> ##2 audio_cfg_out.accuracy ==
            {$past(reg_data_in[2], 2), $past(reg_data_in[0], 2)};
    endproperty
    a_ao_acc: assert property (p_ao_acc)
        else $error("clock accuracy code wrong");
    property p_ao_low;
        audio_cfg_out.output_off |-> !audio_serial_out;
    endproperty
    a_ao_low: assert property (p_ao_low)
        else $error("audio output not low while off");
    property p_audio_src;
        $past(rstn_in, 2) && !audio_cfg_out.output_off |->
            audio_serial_out == (audio_cfg_out.post_conceal ?
            $past(audio_post_conceal_in) : $past(audio_pre_conceal_in));
    endproperty
    a_audio_src: assert property (p_audio_src)
        else $error("audio output follows wrong source");
    property p_speed;
        s_wr(dcr_pkg::ADDR_SPEED) |-> ##2
            drive_cfg_out.double_speed == $past(reg_data_in[3], 2) &&
            drive_cfg_out.mode == mode_of($past(reg_data_in[1:0], 2));
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed or standby mode wrong");
    property p_pll;
        s_wr(dcr_pkg::ADDR_PLL_BW) |-> ##2
            pll_cfg_out == {$past(reg_data_in[1:0], 2),
            $past(reg_data_in[3:2], 2)};
    endproperty
    a_pll: assert property (p_pll)
        else $error("loop filter setting wrong");
    property p_mute_split;
        s_wr(dcr_pkg::ADDR_VPIN_LO) ##0 !reg_data_in[1] |-> ##2
            mute_out == $past(mute_left_in) &&
            versatile_pin_three_out == $past(mute_right_in);
    endproperty
    a_mute_split: assert property (p_mute_split)
        else $error("split mute outputs wrong");
    property p_off_track;
        s_wr(dcr_pkg::ADDR_VPIN_LO) |-> ##2 ($past(reg_data_in[0], 2) ?
            !status_pin_one_out :
            off_track_out == $past(internal_off_track_in));
    endproperty
    a_off_track: assert property (p_off_track)
        else $error("off-track source wrong");
    property p_v4_sub;
        s_wr(dcr_pkg::ADDR_VPIN_HI) ##0 reg_data_in[1:0] == 2'h1 |-> ##2
            versatile_pin_four_out == $past(qw_subcode_in);
    endproperty
    a_v4_sub: assert property (p_v4_sub)
        else $error("pin four not carrying subcode");
    property p_subcode;
        s_wr(dcr_pkg::ADDR_SUBCODE) |-> ##2
            subcode_cfg_out.enable == ($past(reg_data_in[2:0], 2) == 3'h4) &&
            subcode_cfg_out.three_wire == $past(reg_data_in[3], 2);
    endproperty
    a_subcode: assert property (p_subcode)
        else $error("subcode port setting wrong");
endmodule // dcr_top_assertions

bind dcr_top dcr_top_assertions i_dcr_top_assertions (.*);

// ==== dv/tb_dcr_top.sv ====
// Purpose: self-checking bench of the configuration bank
// Assumes: host model writes; bench drives pins 1 ns after edges
// Notes:   one put takes two edges
`timescale 1ns/100ps
module tb_dcr_top;
    logic core_clk_in, rstn_in, reg_wr_in, pll_clock_select_pin_in;
    logic versatile_pin_one_in, audio_pre_conceal_in, audio_post_conceal_in;
    logic mute_left_in, mute_right_in, internal_off_track_in, qw_subcode_in;
    logic deemph_flag_in, motor_a_in, motor_b_in, audio_serial_out;
    logic mute_out, versatile_pin_three_out, versatile_pin_four_out;
    logic versatile_pin_five_out, off_track_out, status_pin_one_out;
    logic [3:0]                reg_addr_in, reg_data_in, d;
    dcr_pkg::dcr_audio_cfg_t   audio_cfg_out;
    dcr_pkg::dcr_drive_cfg_t   drive_cfg_out;
    dcr_pkg::dcr_pll_cfg_t     pll_cfg_out;
    dcr_pkg::dcr_subcode_cfg_t subcode_cfg_out;
    int                        fails = 0;
    int                        compares = 0;

    dcr_top i_dcr_top (.*);
    dcr_host_model i_dcr_host_model
    (
        .clk_in   (core_clk_in),
        .wr_out   (reg_wr_in),
        .addr_out (reg_addr_in),
        .data_out (reg_data_in)
    );

    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // one edge takes the word, the next shows it at the outputs
    task automatic put(input logic [3:0] a, input logic [3:0] v);
        i_dcr_host_model.wr(a, v);
        i_dcr_host_model.idle();
        edges(1);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_reset();
        {pll_clock_select_pin_in, versatile_pin_one_in, audio_pre_conceal_in,
            audio_post_conceal_in, mute_left_in, mute_right_in,
            internal_off_track_in, qw_subcode_in, deemph_flag_in,
            motor_a_in, motor_b_in} = '0;
        rstn_in = 1'b0;
        edges(5);
        rstn_in = 1'b1;
        edges(2);
        chk(16'(audio_cfg_out), 16'h0010);
        chk(16'(drive_cfg_out), 16'h0030);
        chk(16'(pll_cfg_out), 16'h0006);
        chk(16'(subcode_cfg_out), 16'h0000);
        chk(16'({versatile_pin_three_out, versatile_pin_four_out,
            versatile_pin_five_out, mute_out}), 16'h0006);
        $display("reset test done");
    endtask

    task automatic t_audio();
        audio_post_conceal_in = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            d = 4'(i);
            put(dcr_pkg::ADDR_AUDIO_OUT, d);
            chk(16'(audio_cfg_out), 16'({d[1], d[3], d[2] & d[0], d[2],
                d[0]}));
            chk(16'(audio_serial_out), 16'(d[1] & ~(d[2] & d[0])));
        end
        $display("audio output test done");
    endtask

    task automatic t_speed();
        logic [2:0] m;
        for (int i = 0; i < 16; i++)
        begin
            d = 4'(i);
            put(dcr_pkg::ADDR_SPEED, d);
            m = (d[1:0] == 2'h3) ? 3'h4 : (d[1:0] == 2'h2) ? 3'h2 : 3'h1;
            chk(16'(drive_cfg_out[10:5]), 16'({d[3:2], 1'b0, m}));
        end
        pll_clock_select_pin_in = 1'b1;
        edges(6);
        put(dcr_pkg::ADDR_SPEED, 4'h0);
        chk(16'(drive_cfg_out.xtal), 16'(dcr_pkg::XTAL_8M46));
        pll_clock_select_pin_in = 1'b0;
        $display("speed test done");
    endtask

    task automatic t_pins();
        {mute_right_in, versatile_pin_one_in, motor_b_in} = 3'h7;
        edges(6);
        for (int i = 0; i < 16; i++)
        begin
            d = 4'(i);
            put(dcr_pkg::ADDR_VPIN_LO, d);
            chk(16'({mute_out, versatile_pin_three_out}),
                16'({d[1], d[1] ? d[2] : 1'b1}));
            chk(16'({off_track_out, status_pin_one_out}),
                16'({d[0], ~d[0]}));
            put(dcr_pkg::ADDR_VPIN_HI, d);
            chk(16'({drive_cfg_out.motor_4line, drive_cfg_out.deemph_bypass}),
                16'({d == 4'h0, d[3:2] == 2'h1}));
            chk(16'({versatile_pin_four_out, versatile_pin_five_out}),
                16'(d == 4'h0 ? {motor_a_in, motor_b_in} :
                {~^d[1:0], ~^d[3:2]}));
        end
        {qw_subcode_in, deemph_flag_in} = 2'h3;
        put(dcr_pkg::ADDR_VPIN_HI, 4'h5);
        chk(16'({versatile_pin_four_out, versatile_pin_five_out}),
            16'h0003);
        $display("versatile pin test done");
    endtask

    task automatic t_misc();
        for (int i = 0; i < 16; i++)
        begin
            d = 4'(i);
            put(dcr_pkg::ADDR_AUD_MOTOR, d);
            put(dcr_pkg::ADDR_SUBCODE, d);
            chk(16'(drive_cfg_out[4:2]),
                16'({d[3:2] == 2'h1, d[1:0]}));
            chk(16'(subcode_cfg_out), 16'({d[2:0] == 3'h4, d[3]}));
            put(dcr_pkg::ADDR_PLL_BW, d);
            chk(16'(pll_cfg_out), 16'({d[1:0], d[3:2]}));
        end
        // back-to-back words: one to the PLL register, then words to addresses owned by other blocks
        i_dcr_host_model.wr(dcr_pkg::ADDR_PLL_BW, 4'h5);
        for (int a = 0; a < 10; a++)
            if (a != 8)
                i_dcr_host_model.wr(4'(a), 4'hA);
        i_dcr_host_model.idle();
        edges(1);
        chk(16'(pll_cfg_out), 16'h0005);
        $display("option and address test done");
    endtask

    initial
    begin
        #200000;
        fails++;
        end_of_test();
    end

    initial
    begin
        t_reset();
        t_audio();
        t_speed();
        t_pins();
        t_misc();
        t_reset();
        end_of_test();
    end
endmodule // tb_dcr_top
